//--- core/mtseq_pkg.sv
// Package for the measurement trigger sequencer: map, fields, timing
package mtseq_pkg;
    // Register byte offsets
    localparam logic [7:0] MTSEQ_CTRL_OFF = 8'h00;
    localparam logic [7:0] MTSEQ_CMD_OFF = 8'h04;
    localparam logic [7:0] MTSEQ_TCOUNT_OFF = 8'h08;
    localparam logic [7:0] MTSEQ_SCOUNT_OFF = 8'h0C;
    localparam logic [7:0] MTSEQ_STATUS_OFF = 8'h10;
    localparam logic [7:0] MTSEQ_DONECNT_OFF = 8'h14;
    // Command register bit positions (write one to issue)
    localparam int MTSEQ_CMD_INIT = 0;
    localparam int MTSEQ_CMD_READ = 1;
    localparam int MTSEQ_CMD_MEAS = 2;
    localparam int MTSEQ_CMD_CONF = 3;
    localparam int MTSEQ_CMD_SWTRG = 4;
    localparam int MTSEQ_CMD_GET = 5;
    localparam int MTSEQ_CMD_CLRERR = 6;
    // Trigger count write codes for MIN and MAX in bits 17:16
    localparam int MTSEQ_TC_MIN_BIT = 16;
    localparam int MTSEQ_TC_MAX_BIT = 17;
    // Count limits and reset values
    localparam logic [15:0] MTSEQ_TCOUNT_MIN = 16'h0001;
    localparam logic [15:0] MTSEQ_TCOUNT_MAX = 16'hC350;
    localparam logic [15:0] MTSEQ_TCOUNT_RST = 16'h0001;
    localparam logic [15:0] MTSEQ_SCOUNT_RST = 16'h0001;
    // Timing: clock in Hz, setup in ms, derived counts in clock cycles
    localparam int MTSEQ_CLK_HZ = 25_000_000;
    localparam int MTSEQ_SETUP_MS = 20;
    localparam int MTSEQ_SETUP_CYC = MTSEQ_SETUP_MS * (MTSEQ_CLK_HZ / 1000);
    localparam int MTSEQ_SAMPLE_CYC = 4;
    // Trigger source selection
    typedef enum logic [1:0] {
        MTSEQ_SRC_IMM = 2'b00,
        MTSEQ_SRC_EXT = 2'b01,
        MTSEQ_SRC_BUS = 2'b10
    } mtseq_src_t;
    // Sequencer states
    typedef enum logic [1:0] {
        MTSEQ_ST_IDLE = 2'b00,
        MTSEQ_ST_SETUP = 2'b01,
        MTSEQ_ST_WAIT = 2'b10,
        MTSEQ_ST_BURST = 2'b11
    } mtseq_state_t;
endpackage

//--- core/mtseq_ext_trig.sv
// External trigger synchroniser and falling edge detector
`timescale 1ns/10ps
module mtseq_ext_trig (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic trig_in_n,
    output logic fall_pulse
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;

    // two-flop synchroniser; idle level of the line is high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            sync1_q <= trig_in_n;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign fall_pulse = prev_q & ~sync2_q;

    // Each low pulse yields exactly one event
    single_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fall_pulse |=> !fall_pulse) else $error("edge pulse too long");
endmodule // mtseq_ext_trig

//--- core/mtseq_axil.sv
// AXI4-Lite slave front end returning one register access at a time
`timescale 1ns/10ps
module mtseq_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    input wire logic wr_err,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;

    // Take address and data in either order; hold until response done
    assign s_awready = !aw_got_q && !s_bvalid;
    assign s_wready = !w_got_q && !s_bvalid;
    assign wr_en = aw_got_q && w_got_q && !s_bvalid;
    assign wr_addr = awaddr_q;
    assign wr_data = wdata_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            s_bvalid <= 1'b0;
            s_bresp <= 2'b00;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_awaddr;
            end
            // Partial strobes are written whole; all fields sit in byte lanes 0 to 2
            if (s_wvalid && s_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_wdata;
            end
            if (wr_en) begin
                s_bvalid <= 1'b1;
                s_bresp <= wr_err ? 2'b10 : 2'b00;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Read: accepted when idle, data registered next cycle
    assign s_arready = !s_rvalid;
    assign rd_addr = s_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= 2'b00;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_err ? 32'h0000_0000 : rd_data;
            s_rresp <= rd_err ? 2'b10 : 2'b00;
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    bresp_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en |=> s_bvalid) else $error("no write response");
endmodule // mtseq_axil

//--- core/mtseq_top.sv
// Measurement trigger sequencer: arming, sources, counting, completion
//
// How it works
// - In external mode each accepted edge starts one burst of samples.
// - In immediate mode the trigger is always present while waiting.
// - In immediate mode an arm or read-arm starts a burst as soon as setup ends.
// - Configure-and-measure takes exactly one reading, ignoring samples.
// - In bus mode a software trigger counts only while waiting.
// - In bus mode a group execute trigger also counts while waiting.
// - Triggers outside the wait state are ignored.
// - Init or read commands move the sequencer from idle to arming.
// - About 20 ms of setup follows arming; triggers then are dropped.
// - Accepted triggers are counted; the limit (1..50000) ends in idle.
// - Measure and configure commands load the trigger count with 1.
// - Min sets the trigger count to 1 and max sets it to 50000.
// - A measurement-complete output pulses after each burst.
// - External triggers are taken on the falling edge of the line.
// - Source changes outside idle are refused with a conflict flag.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module mtseq_top #(
    parameter int SETUP_CYC = mtseq_pkg::MTSEQ_SETUP_CYC,
    parameter int SAMPLE_CYC = mtseq_pkg::MTSEQ_SAMPLE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic ext_trig_n,
    output logic sample_strobe,
    output logic measurement_done_output
);
    import mtseq_pkg::*;

    // Zero-length setup or sample phases would wrap the down counter
    if (SETUP_CYC < 1 || SAMPLE_CYC < 1) begin : g_bad_cycles
        $error("mtseq_top: cycle counts must be at least one");
    end

    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_err;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    logic ext_fall;

    mtseq_axil u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // relies on a wide pulse so the 40 ns sampler cannot miss it
    mtseq_ext_trig u_ext (
        .aclk(aclk),
        .aresetn(aresetn),
        .trig_in_n(ext_trig_n),
        .fall_pulse(ext_fall)
    );

    mtseq_state_t state_q;
    mtseq_src_t src_q;
    logic [15:0] tcount_q;
    logic [15:0] scount_q;
    logic [15:0] taken_q;
    logic [15:0] samples_left_q;
    logic [31:0] timer_q;
    logic conflict_q;
    logic done_q;
    logic [15:0] done_cnt_q;

    // Address decode helpers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    logic cmd_wr;
    logic ctrl_wr;
    logic tc_wr;
    logic sc_wr;
    assign cmd_wr = wr_en && hit(wr_addr, MTSEQ_CMD_OFF);
    assign ctrl_wr = wr_en && hit(wr_addr, MTSEQ_CTRL_OFF);
    assign tc_wr = wr_en && hit(wr_addr, MTSEQ_TCOUNT_OFF);
    assign sc_wr = wr_en && hit(wr_addr, MTSEQ_SCOUNT_OFF);
    assign wr_err = wr_en && !(cmd_wr || ctrl_wr || tc_wr || sc_wr ||
        hit(wr_addr, MTSEQ_STATUS_OFF) || hit(wr_addr, MTSEQ_DONECNT_OFF));

    logic is_idle;
    logic do_arm;
    logic do_meas;
    logic do_conf;
    assign is_idle = state_q == MTSEQ_ST_IDLE;
    // init or read arm from idle only
    assign do_arm = cmd_wr && is_idle && (wr_data[MTSEQ_CMD_INIT] ||
        wr_data[MTSEQ_CMD_READ]);
    assign do_meas = cmd_wr && is_idle && wr_data[MTSEQ_CMD_MEAS];
    assign do_conf = cmd_wr && is_idle && wr_data[MTSEQ_CMD_CONF];

    // Trigger qualification per source
    logic trig_now;
    always_comb begin
        trig_now = 1'b0;
        case (src_q)
            MTSEQ_SRC_IMM: trig_now = 1'b1;
            MTSEQ_SRC_EXT: trig_now = ext_fall;
            MTSEQ_SRC_BUS: trig_now = cmd_wr &&
                (wr_data[MTSEQ_CMD_SWTRG] || wr_data[MTSEQ_CMD_GET]);
            default: trig_now = 1'b0;
        endcase
    end

    logic trig_acc;
    assign trig_acc = trig_now && state_q == MTSEQ_ST_WAIT;

    logic burst_end;
    assign burst_end = state_q == MTSEQ_ST_BURST && timer_q == 32'd0 &&
        samples_left_q == 16'd1;

    // Main sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= MTSEQ_ST_IDLE;
            taken_q <= 16'd0;
            samples_left_q <= 16'd0;
            timer_q <= 32'd0;
        end else begin
            case (state_q)
                MTSEQ_ST_IDLE: begin
                    taken_q <= 16'd0;
                    if (do_meas) begin
                        state_q <= MTSEQ_ST_BURST;
                        samples_left_q <= 16'd1;
                        timer_q <= 32'(SAMPLE_CYC - 1);
                        taken_q <= 16'd1;
                    end else if (do_arm) begin
                        state_q <= MTSEQ_ST_SETUP;
                        timer_q <= 32'(SETUP_CYC - 1);
                    end
                end
                MTSEQ_ST_SETUP: begin
                    if (timer_q == 32'd0) begin
                        state_q <= MTSEQ_ST_WAIT;
                    end else begin
                        timer_q <= timer_q - 32'd1;
                    end
                end
                MTSEQ_ST_WAIT: begin
                    if (trig_acc) begin
                        taken_q <= taken_q + 16'd1;
                        state_q <= MTSEQ_ST_BURST;
                        samples_left_q <= scount_q;
                        timer_q <= 32'(SAMPLE_CYC - 1);
                    end
                end
                MTSEQ_ST_BURST: begin
                    if (timer_q != 32'd0) begin
                        timer_q <= timer_q - 32'd1;
                    end else if (samples_left_q != 16'd1) begin
                        samples_left_q <= samples_left_q - 16'd1;
                        timer_q <= 32'(SAMPLE_CYC - 1);
                    end else if (taken_q >= tcount_q) begin
                        state_q <= MTSEQ_ST_IDLE;
                    end else begin
                        state_q <= MTSEQ_ST_WAIT;
                    end
                end
                default: state_q <= MTSEQ_ST_IDLE;
            endcase
        end
    end

    // Sample strobe marks the end of each reading
    assign sample_strobe = state_q == MTSEQ_ST_BURST && timer_q == 32'd0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
            done_cnt_q <= 16'd0;
        end else begin
            done_q <= burst_end;
            if (burst_end) begin
                done_cnt_q <= done_cnt_q + 16'd1;
            end
        end
    end
    assign measurement_done_output = done_q;

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_q <= MTSEQ_SRC_IMM;
            tcount_q <= MTSEQ_TCOUNT_RST;
            scount_q <= MTSEQ_SCOUNT_RST;
            conflict_q <= 1'b0;
        end else begin
            if (do_meas || do_conf) begin
                // count to 1, source to immediate
                tcount_q <= MTSEQ_TCOUNT_MIN;
                src_q <= MTSEQ_SRC_IMM;
            end else if (tc_wr && is_idle) begin
                // min and max codes, else clamp to range
                if (wr_data[MTSEQ_TC_MAX_BIT]) begin
                    tcount_q <= MTSEQ_TCOUNT_MAX;
                end else if (wr_data[MTSEQ_TC_MIN_BIT] ||
                    wr_data[15:0] == 16'd0) begin
                    tcount_q <= MTSEQ_TCOUNT_MIN;
                end else if (wr_data[15:0] > MTSEQ_TCOUNT_MAX) begin
                    tcount_q <= MTSEQ_TCOUNT_MAX;
                end else begin
                    tcount_q <= wr_data[15:0];
                end
            end
            if (sc_wr && is_idle) begin
                scount_q <= (wr_data[15:0] == 16'd0) ? 16'd1 : wr_data[15:0];
            end
            // source change only in idle; set wins over clear
            if (ctrl_wr && is_idle && !do_conf && !do_meas) begin
                src_q <= mtseq_src_t'(wr_data[1:0] == 2'b11 ? 2'b00
                    : wr_data[1:0]);
            end
            if (ctrl_wr && !is_idle) begin
                conflict_q <= 1'b1;
            end else if (cmd_wr && wr_data[MTSEQ_CMD_CLRERR]) begin
                conflict_q <= 1'b0;
            end
        end
    end

    // Read mux
    always_comb begin
        rd_err = 1'b0;
        case (rd_addr)
            MTSEQ_CTRL_OFF: rd_data = {30'd0, src_q};
            MTSEQ_CMD_OFF: rd_data = 32'h0000_0000;
            MTSEQ_TCOUNT_OFF: rd_data = {16'd0, tcount_q};
            MTSEQ_SCOUNT_OFF: rd_data = {16'd0, scount_q};
            MTSEQ_STATUS_OFF: rd_data = {13'd0, conflict_q, state_q, taken_q};
            MTSEQ_DONECNT_OFF: rd_data = {16'd0, done_cnt_q};
            default: begin
                rd_data = 32'h0000_0000;
                rd_err = 1'b1;
            end
        endcase
    end

    // Setup lasts the full count with no early acceptance
    logic [31:0] setup_seen_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            setup_seen_q <= 32'd0;
        end else if (state_q == MTSEQ_ST_SETUP) begin
            setup_seen_q <= setup_seen_q + 32'd1;
        end else begin
            setup_seen_q <= 32'd0;
        end
    end

    setup_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == MTSEQ_ST_SETUP ##1 state_q == MTSEQ_ST_WAIT
        |-> setup_seen_q == 32'(SETUP_CYC)) else $error("bad setup");
    arm_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_arm |=> state_q == MTSEQ_ST_SETUP) else $error("no arm");
    ignore_trig_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q != MTSEQ_ST_WAIT && state_q != MTSEQ_ST_BURST
        |=> $stable(taken_q) || taken_q == 16'd0 || taken_q == 16'd1)
        else $error("trigger outside wait");
    accept_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
        trig_acc |=> state_q == MTSEQ_ST_BURST && taken_q == $past(taken_q)
        + 16'd1) else $error("trigger not taken");
    count_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        burst_end && taken_q >= tcount_q |=> is_idle)
        else $error("limit not honoured");
    imm_fire_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == MTSEQ_ST_WAIT && src_q == MTSEQ_SRC_IMM
        |=> state_q == MTSEQ_ST_BURST) else $error("immediate idle");
    meas_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_meas |=> samples_left_q == 16'd1 && tcount_q == 16'd1)
        else $error("measure not single");
    done_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        burst_end |=> measurement_done_output ##1 !measurement_done_output)
        else $error("done pulse wrong");
    conflict_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_wr && !is_idle |=> conflict_q && $stable(src_q))
        else $error("source changed while busy");
    bus_trig_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == MTSEQ_ST_WAIT && src_q == MTSEQ_SRC_BUS && !cmd_wr
        |=> state_q == MTSEQ_ST_WAIT) else $error("bus trigger stray");

    ext_burst_c: cover property (@(posedge aclk) disable iff (!aresetn)
        src_q == MTSEQ_SRC_EXT && trig_acc);
    bus_burst_c: cover property (@(posedge aclk) disable iff (!aresetn)
        src_q == MTSEQ_SRC_BUS && trig_acc);
    limit_end_c: cover property (@(posedge aclk) disable iff (!aresetn)
        burst_end && taken_q >= tcount_q && tcount_q > 16'd1);
    read_arm_c: cover property (@(posedge aclk) disable iff (!aresetn)
        do_arm && wr_data[MTSEQ_CMD_READ]);
    conf_cmd_c: cover property (@(posedge aclk) disable iff (!aresetn)
        do_conf);
endmodule // mtseq_top

//--- verif/mtseq_trig_src.sv
// External trigger source model driving the low-true trigger line
`timescale 1ns/10ps
module mtseq_trig_src #(
    parameter int LOW_CYC = 30
) (
    input wire logic aclk,
    input wire logic fire,
    output logic ext_trig_n
);
    int cnt = 0;
    // low pulse over 1 us: 30 cycles of 40 ns gives margin
    always_ff @(posedge aclk) begin
        if (fire) begin
            cnt <= LOW_CYC;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // Pulled up when released, so the idle level is high
    assign ext_trig_n = (cnt == 0);
endmodule // mtseq_trig_src

//--- verif/mtseq_tb_top.sv
// Self-checking bench for the measurement trigger sequencer
`timescale 1ns/10ps
module mtseq_tb_top;
    import mtseq_pkg::*;
    localparam int SETUP = 100;
    localparam int CEIL = 20000;
    typedef struct {logic [31:0] wv; logic [31:0] ev;} mtseq_row_t;
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic fire = 0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rd_v;
    logic [1:0] rsp;
    logic [1:0] wsp;
    wire logic awready, wready, bvalid, arready, rvalid, trig_n, strobe, done;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int miscompares = 0, checks = 0, cycles = 0, strobes = 0, dones = 0;
    int s0, d0;
    mtseq_row_t rows [6] = '{
        '{32'h0000_0000, 32'h0000_0001}, '{32'h0000_0005, 32'h0000_0005},
        '{32'h0000_C350, 32'h0000_C350}, '{32'h0000_C351, 32'h0000_C350},
        '{32'h0001_0007, 32'h0000_0001}, '{32'h0002_0000, 32'h0000_C350}};

    mtseq_top #(.SETUP_CYC(SETUP), .SAMPLE_CYC(MTSEQ_SAMPLE_CYC))
        mtseq_top_inst (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
        .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
        .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
        .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
        .s_rready(rready), .ext_trig_n(trig_n), .sample_strobe(strobe),
        .measurement_done_output(done));
    mtseq_trig_src mtseq_trig_src_inst (.aclk(aclk), .fire(fire),
        .ext_trig_n(trig_n));

    initial begin
        forever #20 aclk = ~aclk;
    end
    // Counts strobes and done pulses; the ceiling cuts a hang short
    always @(posedge aclk) begin
        cycles++;
        if (strobe === 1'b1) strobes++;
        if (done === 1'b1) dones++;
        if (cycles == CEIL) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Offers address and data together, releases each as it is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ta, tw;
        ta = 0;
        tw = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            ta = ta | (awready & awvalid);
            tw = tw | (wready & wvalid);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        wsp = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!(arready & arvalid));
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd_v = rdata;
        rsp = rresp;
        rready <= 0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
        rd(a);
        chk(rd_v & m, e);
    endtask
    task automatic cmd(input int b);
        wr(MTSEQ_CMD_OFF, 32'(1 << b));
    endtask
    task automatic pulse();
        @(posedge aclk);
        fire <= 1;
        @(posedge aclk);
        fire <= 0;
        // A new fire while the line is low would only stretch the pulse
        do @(posedge aclk); while (trig_n !== 1'b1);
    endtask
    task automatic wait_done(input int n);
        while (dones < n) @(posedge aclk);
        repeat (3) @(posedge aclk);
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        // Reset values: idle, immediate source, counts of one
        rdchk(MTSEQ_CTRL_OFF, 32'h0000_0003, 32'h0000_0000);
        rdchk(MTSEQ_TCOUNT_OFF, 32'h0000_FFFF, 32'h0000_0001);
        rdchk(MTSEQ_SCOUNT_OFF, 32'h0000_FFFF, 32'h0000_0001);
        rdchk(MTSEQ_STATUS_OFF, 32'h0007_0000, 32'h0000_0000);
        $display("test reset done");
        // clamp, zero, min and max codes
        foreach (rows[i]) begin
            wr(MTSEQ_TCOUNT_OFF, rows[i].wv);
            rdchk(MTSEQ_TCOUNT_OFF, 32'h0000_FFFF, rows[i].ev);
        end
        rd(8'h18);
        chk({30'h0, rsp}, 32'h0000_0002);
        chk(rd_v, 32'h0000_0000);
        wr(8'h18, 32'h0000_0000);
        chk({30'h0, wsp}, 32'h0000_0002);
        $display("test count table done");
        // arm in immediate mode runs the sample count as soon as setup ends
        wr(MTSEQ_TCOUNT_OFF, 32'h0000_0001);
        chk({30'h0, wsp}, 32'h0000_0000);
        wr(MTSEQ_SCOUNT_OFF, 32'h0000_0003);
        cmd(MTSEQ_CMD_INIT);
        wait_done(1);
        chk(32'(strobes), 32'h0000_0003);
        rdchk(MTSEQ_STATUS_OFF, 32'h0003_0000, 32'h0000_0000);
        rdchk(MTSEQ_DONECNT_OFF, 32'h0000_FFFF, 32'h0000_0001);
        // Measure takes one reading whatever the sample count
        wr(MTSEQ_TCOUNT_OFF, 32'h0000_0007);
        cmd(MTSEQ_CMD_MEAS);
        wait_done(2);
        chk(32'(strobes), 32'h0000_0004);
        rdchk(MTSEQ_TCOUNT_OFF, 32'h0000_FFFF, 32'h0000_0001);
        $display("test immediate done");
        // External source: a pulse inside setup must be dropped
        wr(MTSEQ_CTRL_OFF, 32'h0000_0001);
        wr(MTSEQ_TCOUNT_OFF, 32'h0000_0002);
        wr(MTSEQ_SCOUNT_OFF, 32'h0000_0001);
        s0 = strobes;
        d0 = dones;
        cmd(MTSEQ_CMD_INIT);
        pulse();
        repeat (SETUP + 40) @(posedge aclk);
        chk(32'(dones - d0), 32'h0000_0000);
        wr(MTSEQ_CTRL_OFF, 32'h0000_0002);
        rdchk(MTSEQ_STATUS_OFF, 32'h0004_0000, 32'h0004_0000);
        rdchk(MTSEQ_CTRL_OFF, 32'h0000_0003, 32'h0000_0001);
        pulse();
        wait_done(d0 + 1);
        pulse();
        wait_done(d0 + 2);
        chk(32'(strobes - s0), 32'h0000_0002);
        rdchk(MTSEQ_STATUS_OFF, 32'h0003_0000, 32'h0000_0000);
        pulse();
        repeat (60) @(posedge aclk);
        chk(32'(dones - d0), 32'h0000_0002);
        $display("test external done");
        // Bus source: software trigger refused in idle, then taken
        cmd(MTSEQ_CMD_CLRERR);
        rdchk(MTSEQ_STATUS_OFF, 32'h0004_0000, 32'h0000_0000);
        wr(MTSEQ_CTRL_OFF, 32'h0000_0002);
        d0 = dones;
        cmd(MTSEQ_CMD_SWTRG);
        repeat (20) @(posedge aclk);
        chk(32'(dones - d0), 32'h0000_0000);
        cmd(MTSEQ_CMD_INIT);
        repeat (SETUP + 10) @(posedge aclk);
        cmd(MTSEQ_CMD_SWTRG);
        wait_done(d0 + 1);
        chk(32'(dones - d0), 32'h0000_0001);
        cmd(MTSEQ_CMD_GET);
        wait_done(d0 + 2);
        rdchk(MTSEQ_STATUS_OFF, 32'h0003_0000, 32'h0000_0000);
        $display("test bus done");
        // Configure restores immediate source and count one; read-arm fires
        cmd(MTSEQ_CMD_CONF);
        rdchk(MTSEQ_CTRL_OFF, 32'h0000_0003, 32'h0000_0000);
        rdchk(MTSEQ_TCOUNT_OFF, 32'h0000_FFFF, 32'h0000_0001);
        cmd(MTSEQ_CMD_READ);
        wait_done(d0 + 3);
        chk(32'(dones - d0), 32'h0000_0003);
        rdchk(MTSEQ_STATUS_OFF, 32'h0003_0000, 32'h0000_0000);
        $display("test configure done");
        conclude();
    end
endmodule // mtseq_tb_top
